//--- rtl/intc_mode_ctrl.sv
// Purpose: Interrupt control mode, NMI edge and CPU/DMA priority registers
// Assumes: Inputs synchronous to sys_clk; one AXI4-Lite master
// Notes: Prohibited mode codes are stored as written; see handover
`timescale 1ns/1ps
`include "intc_mode_regs.svh"
// Overview of operation
// - Mode code 00 selects mode 0, masking by the single mask bit only.
// - Mode code 10 selects mode 2, masking by the three-bit mask and sources.
// - Edge select 0 raises a nonmaskable request on a falling input edge.
// - Edge select 1 raises a nonmaskable request on a rising input edge.
// - Mode register bits 7, 6 and 2 to 0 read zero, ignore writes.
// - Arbitration enable 0 gives the CPU the lowest priority against DMA.
// - Arbitration enable 1 lets the CPU arbitrate with its three-bit level.
// - Priority level is binary, 000 lowest through 111 highest.
// - Auto set 1 loads the level continuously from the current CPU mask.
// - While auto set is 1, software writes to the level are ignored.
// - While auto set is 0, the level holds its last value and changes only on a software write.
// - Priority register bits 6 to 4 read zero; software writes zero.
// - In mode 2 each maskable source carries a level 7 down to 0.
module intc_mode_ctrl #(
    parameter int LEVEL_W = 3
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic [3:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [3:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic nmi_in,
    input wire logic ccr_mask_bit,
    input wire logic [LEVEL_W-1:0] exr_mask,
    input wire logic [LEVEL_W-1:0] source_level,
    input wire logic source_req,
    output logic nmi_request,
    output logic mode2_active,
    output logic [LEVEL_W-1:0] cpu_arb_level,
    output logic [LEVEL_W-1:0] source_arb_level,
    output logic maskable_accept
);
    logic rst_meta_n;
    logic rst_sync_n;
    logic [1:0] mode_sel;
    logic nmi_edge_sel;
    intc_mode_pkg::cpu_prio_t prio;
    logic nmi_prev;
    intc_mode_pkg::bus_state_t wstate;
    intc_mode_pkg::bus_state_t rstate;
    logic [3:0] aw_addr;
    logic aw_held;
    logic [7:0] w_byte;
    logic w_ok;
    logic w_held;

    // Reset release through two flops so deassertion is clean
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_meta_n <= 1'b0;
            rst_sync_n <= 1'b0;
        end else begin
            rst_meta_n <= 1'b1;
            rst_sync_n <= rst_meta_n;
        end
    end

    // Register images as read back; unused bits stay zero
    wire [7:0] mode_ctrl_img = {2'b00, mode_sel, nmi_edge_sel, 3'b000};
    wire [7:0] prio_ctrl_img = {prio.arb_enable, 3'b000, prio.auto_set,
                                prio.level};

    // Write decode, both channels taken before a write lands
    wire do_write = aw_held && w_held && (wstate == intc_mode_pkg::bus_idle);
    wire wr_mode = do_write && aw_addr == `MODE_CTRL_OFFSET && w_ok;
    wire wr_prio = do_write && aw_addr == `PRIO_CTRL_OFFSET && w_ok;
    wire wr_known = aw_addr == `MODE_CTRL_OFFSET ||
                    aw_addr == `PRIO_CTRL_OFFSET;
    wire [7:0] mode_wval = w_byte & `MODE_CTRL_WMASK;
    wire [7:0] prio_wval = w_byte & `PRIO_CTRL_WMASK;

    // Current CPU mask widened to a level; mode 0 mask maps to 0 or 7
    wire is_mode2 = mode_sel == `MODE2_CODE;
    wire [LEVEL_W-1:0] cur_mask = is_mode2 ? exr_mask :
        {LEVEL_W{ccr_mask_bit}};

    // Level source: hardware in auto mode, software write otherwise
    wire [LEVEL_W-1:0] next_level =
        prio.auto_set ? cur_mask :
        wr_prio ? prio_wval[LEVEL_W-1:0] :
        prio.level;
    wire next_auto = wr_prio ? prio_wval[`AUTO_SET_BIT] : prio.auto_set;
    wire next_arb = wr_prio ? prio_wval[`ARB_ENABLE_BIT] : prio.arb_enable;

    // Edge detect on the nonmaskable input by selected polarity
    wire nmi_fall = nmi_prev && !nmi_in;
    wire nmi_rise = !nmi_prev && nmi_in;
    wire next_nmi_req = nmi_edge_sel ? nmi_rise : nmi_fall;

    // Mask gate: mode 0 uses the single bit, mode 2 compares levels
    wire next_accept = is_mode2 ?
        (source_req && source_level > exr_mask) :
        (source_req && !ccr_mask_bit);

    // Arbitration level: lowest unless enabled, binary level otherwise
    wire [LEVEL_W-1:0] next_cpu_arb = prio.arb_enable ? prio.level :
        {LEVEL_W{1'b0}};

    // Control registers
    always_ff @(posedge sys_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            mode_sel <= `MODE0_CODE;
            // Both register images reset to all zeros
            nmi_edge_sel <= 1'b0;
            prio <= '0;
        end else begin
            if (wr_mode) begin
                mode_sel <= {mode_wval[`MODE_SEL_HI_BIT],
                             mode_wval[`MODE_SEL_LO_BIT]};
                nmi_edge_sel <= mode_wval[`NMI_EDGE_BIT];
            end
            prio <= {next_arb, next_auto, next_level};
        end
    end

    // Output flops for the arbitration and request side
    always_ff @(posedge sys_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            nmi_prev <= 1'b1;
            nmi_request <= 1'b0;
            mode2_active <= 1'b0;
            cpu_arb_level <= '0;
            source_arb_level <= '0;
            maskable_accept <= 1'b0;
        end else begin
            nmi_prev <= nmi_in;
            nmi_request <= next_nmi_req;
            mode2_active <= is_mode2;
            cpu_arb_level <= next_cpu_arb;
            source_arb_level <= is_mode2 ? source_level : '0;
            maskable_accept <= next_accept;
        end
    end

    // Write channel: hold address and data until both are in hand
    always_ff @(posedge sys_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            wstate <= intc_mode_pkg::bus_idle;
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= '0;
            w_byte <= '0;
            w_ok <= 1'b0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `RESP_OKAY;
        end else begin
            s_axi_awready <= !aw_held && !s_axi_awready && s_axi_awvalid &&
                             wstate == intc_mode_pkg::bus_idle;
            s_axi_wready <= !w_held && !s_axi_wready && s_axi_wvalid &&
                            wstate == intc_mode_pkg::bus_idle;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held <= 1'b1;
                aw_addr <= {s_axi_awaddr[3:2], 2'b00};
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held <= 1'b1;
                w_byte <= s_axi_wdata[7:0];
                w_ok <= s_axi_wstrb[0];
            end
            unique case (wstate)
                intc_mode_pkg::bus_idle: begin
                    if (do_write) begin
                        wstate <= intc_mode_pkg::bus_resp;
                        s_axi_bvalid <= 1'b1;
                        s_axi_bresp <= wr_known ? `RESP_OKAY : `RESP_SLVERR;
                        aw_held <= 1'b0;
                        w_held <= 1'b0;
                    end
                end
                intc_mode_pkg::bus_resp: begin
                    if (s_axi_bready) begin
                        wstate <= intc_mode_pkg::bus_idle;
                        s_axi_bvalid <= 1'b0;
                    end
                end
            endcase
        end
    end

    // Read decode; the input port word shows the live CPU mask
    wire [3:0] rd_addr = {s_axi_araddr[3:2], 2'b00};
    wire [31:0] rd_word =
        rd_addr == `MODE_CTRL_OFFSET ? {24'h000000, mode_ctrl_img} :
        rd_addr == `PRIO_CTRL_OFFSET ? {24'h000000, prio_ctrl_img} :
        {29'h00000000, cur_mask};
    wire rd_known = rd_addr == `MODE_CTRL_OFFSET ||
                    rd_addr == `PRIO_CTRL_OFFSET ||
                    rd_addr == `PRIO_INPUT_OFFSET;

    // Read channel: one read at a time
    always_ff @(posedge sys_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            rstate <= intc_mode_pkg::bus_idle;
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= `RESP_OKAY;
        end else begin
            s_axi_arready <= 1'b0;
            unique case (rstate)
                intc_mode_pkg::bus_idle: begin
                    if (s_axi_arvalid && !s_axi_arready) begin
                        s_axi_arready <= 1'b1;
                        s_axi_rvalid <= 1'b1;
                        s_axi_rdata <= rd_known ? rd_word : 32'h00000000;
                        s_axi_rresp <= rd_known ? `RESP_OKAY : `RESP_SLVERR;
                        rstate <= intc_mode_pkg::bus_resp;
                    end
                end
                intc_mode_pkg::bus_resp: begin
                    if (s_axi_rready) begin
                        s_axi_rvalid <= 1'b0;
                        rstate <= intc_mode_pkg::bus_idle;
                    end
                end
            endcase
        end
    end

    // Checks next to the logic
    a_auto_level_follow: assert property (
        @(posedge sys_clk) disable iff (!rst_sync_n)
        prio.auto_set |=> prio.level == $past(cur_mask))
        else $error("auto level did not follow mask");
    a_level_hold_manual: assert property (
        @(posedge sys_clk) disable iff (!rst_sync_n)
        (!prio.auto_set && !wr_prio) |=> $stable(prio.level))
        else $error("manual level changed without write");
    a_lowest_when_off: assert property (
        @(posedge sys_clk) disable iff (!rst_sync_n)
        !prio.arb_enable |=> cpu_arb_level == 3'h0)
        else $error("cpu not lowest while disabled");
    a_level_when_on: assert property (
        @(posedge sys_clk) disable iff (!rst_sync_n)
        prio.arb_enable |=> cpu_arb_level == $past(prio.level))
        else $error("cpu level not used while enabled");
    // Edge checks skip the first edge after reset, where the previous
    // pin sample still belongs to the reset period
    a_nmi_fall_edge: assert property (
        @(posedge sys_clk) disable iff (!rst_sync_n)
        ($past(rst_sync_n) && !nmi_edge_sel && $fell(nmi_in)) |=>
            nmi_request)
        else $error("falling nmi edge missed");
    a_nmi_rise_edge: assert property (
        @(posedge sys_clk) disable iff (!rst_sync_n)
        ($past(rst_sync_n) && nmi_edge_sel && $rose(nmi_in)) |=>
            nmi_request)
        else $error("rising nmi edge missed");
    // Reserved bits are checked on the bus, where software sees them
    a_mode_reserved_zero: assert property (
        @(posedge sys_clk) disable iff (!rst_sync_n)
        ($rose(s_axi_rvalid) && $past(rd_addr == `MODE_CTRL_OFFSET)) |->
            (s_axi_rdata & ~{24'h000000, `MODE_CTRL_WMASK}) == 32'h0)
        else $error("mode reserved bits not zero");
    a_prio_reserved_zero: assert property (
        @(posedge sys_clk) disable iff (!rst_sync_n)
        ($rose(s_axi_rvalid) && $past(rd_addr == `PRIO_CTRL_OFFSET)) |->
            (s_axi_rdata & ~{24'h000000, `PRIO_CTRL_WMASK}) == 32'h0)
        else $error("priority reserved bits not zero");
    a_mode0_gate: assert property (
        @(posedge sys_clk) disable iff (!rst_sync_n)
        (!is_mode2 && ccr_mask_bit) |=> !maskable_accept)
        else $error("mode 0 accepted while masked");
    // A manual write must land whole when hardware does not own the level
    a_level_write_lands: assert property (
        @(posedge sys_clk) disable iff (!rst_sync_n)
        (!prio.auto_set && wr_prio) |=> prio.level == $past(prio_wval[2:0]))
        else $error("manual level write lost");
    // Mode 2 gate: a source at or below the mask is held off
    a_mode2_gate: assert property (
        @(posedge sys_clk) disable iff (!rst_sync_n)
        (is_mode2 && source_level <= exr_mask) |=> !maskable_accept)
        else $error("mode 2 accepted at or below mask");
    a_mode2_accept: assert property (
        @(posedge sys_clk) disable iff (!rst_sync_n)
        (is_mode2 && source_req && source_level > exr_mask) |=>
            maskable_accept)
        else $error("mode 2 refused above mask");
endmodule : intc_mode_ctrl

//--- rtl/intc_mode_regs.svh
// Purpose: Offsets, field positions, reset values of the mode block
// Assumes: 32-bit AXI4-Lite data, byte addresses
// Notes: Registers sit in the low byte of each word
`ifndef INTC_MODE_REGS_SVH
`define INTC_MODE_REGS_SVH
`define MODE_CTRL_OFFSET 4'h0
`define PRIO_CTRL_OFFSET 4'h4
`define PRIO_INPUT_OFFSET 4'h8
`define MODE_CTRL_RESET 8'h00
`define PRIO_CTRL_RESET 8'h00
`define MODE_CTRL_WMASK 8'h38
`define PRIO_CTRL_WMASK 8'h8f
`define MODE_SEL_HI_BIT 5
`define MODE_SEL_LO_BIT 4
`define NMI_EDGE_BIT 3
`define ARB_ENABLE_BIT 7
`define AUTO_SET_BIT 3
`define MODE0_CODE 2'b00
`define MODE2_CODE 2'b10
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10
`endif

//--- rtl/intc_mode_pkg.sv
// Purpose: Types of the interrupt mode and CPU priority block
// Assumes: Nothing beyond the register header
// Notes: Structs carry the packed control fields
package intc_mode_pkg;
    typedef enum logic [1:0] {
        ctl_mode0 = 2'b00,
        ctl_mode2 = 2'b10
    } ctl_mode_t;
    typedef struct packed {
        logic arb_enable;
        logic auto_set;
        logic [2:0] level;
    } cpu_prio_t;
    typedef enum logic [1:0] {
        bus_idle = 2'b01,
        bus_resp = 2'b10
    } bus_state_t;
endpackage : intc_mode_pkg

//--- tb/cpu_dma_model.sv
// Purpose: CPU core and DMA arbiter facing the mode block
// Assumes: Bench names the wanted CPU lines; model launches them on edges
// Notes: DMA level is a parameter; DMA wins ties with the CPU
`timescale 1ns/1ps
module cpu_dma_model #(
    parameter int DMA_LEVEL = 3
) (
    input wire logic sys_clk,
    input wire logic [8:0] want,
    input wire logic [2:0] cpu_arb_level,
    output logic [8:0] pins,
    output logic dma_grant
);
    // Mask, request and NMI lines change only just after an edge
    always_ff @(posedge sys_clk) begin
        pins <= want;
    end
    // Level 0 means the CPU never beats a waiting transfer
    assign dma_grant = cpu_arb_level <= 3'(DMA_LEVEL);
endmodule : cpu_dma_model

//--- tb/tb.sv
// Purpose: Register and arbitration checks of the mode block
// Assumes: One AXI4-Lite master; pins = {req, level, mask3, mask1, nmi}
// Notes: Only legal mode codes and zero priority reserved bits are written
`timescale 1ns/1ps
module tb;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [3:0] awaddr = 4'h0, araddr = 4'h0;
    logic [31:0] wdata = 32'h0, rdata;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, dma_grant;
    logic [1:0] bresp, rresp;
    logic [8:0] want = 9'h001, pins;
    logic nmi_request, mode2_active, maskable_accept;
    logic [2:0] cpu_arb_level, source_arb_level;
    logic [3:0] wstrb = 4'hf;
    wire [4:0] gate_view = {mode2_active, maskable_accept, source_arb_level};
    int err_total = 0, checks_done = 0, pulses = 0;
    int pulses_base = 0;
    // Free-running system clock
    always #20 sys_clk = ~sys_clk;
    intc_mode_ctrl intc_mode_ctrl_i (.sys_clk(sys_clk), .rst_n(rst_n),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .nmi_in(pins[0]),
        .ccr_mask_bit(pins[1]), .exr_mask(pins[4:2]),
        .source_level(pins[7:5]), .source_req(pins[8]),
        .nmi_request(nmi_request), .mode2_active(mode2_active),
        .cpu_arb_level(cpu_arb_level), .source_arb_level(source_arb_level),
        .maskable_accept(maskable_accept));
    cpu_dma_model cpu_dma_model_i (.sys_clk(sys_clk), .want(want),
        .cpu_arb_level(cpu_arb_level), .pins(pins), .dma_grant(dma_grant));
    // Count one-cycle NMI pulses
    always @(posedge sys_clk) begin
        if (nmi_request === 1'b1) pulses++;
    end
    task automatic report_and_stop;
        if (err_total == 0 && checks_done > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : report_and_stop
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value at %0t: got %h expected %h", $time, got,
                exp);
        end
    endtask : chk
    // Each channel is released at the edge that takes it
    task automatic wr(input logic [3:0] a, input logic [31:0] d,
        input logic [1:0] er);
        @(posedge sys_clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge sys_clk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid);
        bready <= 1'b0;
        chk(bresp, er);
    endtask : wr
    task automatic rd(input logic [3:0] a, input logic [31:0] e,
        input logic [1:0] er);
        @(posedge sys_clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge sys_clk); while (!rvalid);
        arvalid <= 1'b0;
        rready <= 1'b0;
        chk(rdata, e);
        chk(rresp, er);
    endtask : rd
    // Model latches, then registered outputs and the auto copy settle
    task automatic setp(input logic [8:0] v);
        want <= v;
        repeat (4) @(posedge sys_clk);
    endtask : setp
    // Hang guard, well past the expected run length
    initial begin
        #400us;
        err_total++;
        report_and_stop();
    end
    initial begin
        repeat (20) @(posedge sys_clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge sys_clk);
        rd(4'h0, 32'h0, 2'b00);
        rd(4'h4, 32'h0, 2'b00);
        chk(cpu_arb_level, 32'h0);
        rd(4'hc, 32'h0, 2'b10);
        wr(4'hc, 32'hff, 2'b10);
        // Mode 2: reserved bits dropped, mask bit of mode 0 ignored
        wr(4'h0, 32'he7, 2'b00);
        rd(4'h0, 32'h20, 2'b00);
        setp(9'h1af);
        chk(gate_view, 32'h1d);
        setp(9'h14f);
        chk({maskable_accept, source_arb_level}, 32'h2);
        // Mode 0: only the single mask bit gates
        wr(4'h0, 32'h00, 2'b00);
        setp(9'h1ad);
        chk(gate_view, 32'h8);
        setp(9'h1af);
        chk(maskable_accept, 32'h0);
        rd(4'h8, 32'h7, 2'b00);
        // Manual level, arbitration on and off
        wr(4'h4, 32'h85, 2'b00);
        rd(4'h4, 32'h85, 2'b00);
        chk({cpu_arb_level, dma_grant}, 32'ha);
        wr(4'h4, 32'h07, 2'b00);
        rd(4'h4, 32'h07, 2'b00);
        chk({cpu_arb_level, dma_grant}, 32'h1);
        // Auto copy from the mode 0 mask bit, set and then clear
        wr(4'h4, 32'h88, 2'b00);
        repeat (2) @(posedge sys_clk);
        rd(4'h4, 32'h8f, 2'b00);
        setp(9'h1ad);
        rd(4'h4, 32'h88, 2'b00);
        // Auto copy from the three-bit mask in mode 2
        wr(4'h0, 32'h20, 2'b00);
        setp(9'h1b9);
        rd(4'h4, 32'h8e, 2'b00);
        chk({cpu_arb_level, dma_grant}, 32'hc);
        rd(4'h8, 32'h6, 2'b00);
        wr(4'h4, 32'h89, 2'b00);
        rd(4'h4, 32'h8e, 2'b00);
        // Auto is still set when this write lands, so the level stays 6
        wr(4'h4, 32'h82, 2'b00);
        setp(9'h1a5);
        rd(4'h4, 32'h86, 2'b00);
        // NMI on falling edges, then on rising edges only
        pulses_base = pulses;
        setp(9'h1a4);
        setp(9'h1a5);
        chk(pulses - pulses_base, 32'h1);
        wr(4'h0, 32'h28, 2'b00);
        rd(4'h0, 32'h28, 2'b00);
        setp(9'h1a4);
        chk(pulses - pulses_base, 32'h1);
        setp(9'h1a5);
        chk(pulses - pulses_base, 32'h2);
        // A write without the low byte strobe leaves the register alone
        wstrb <= 4'he;
        wr(4'h0, 32'h00, 2'b00);
        wstrb <= 4'hf;
        rd(4'h0, 32'h28, 2'b00);
        report_and_stop();
    end
endmodule : tb
